// >>> shared/oen_pkg.sv
package oen_pkg;
   localparam int NUM_LOGS = 4;
   localparam int ADDR_W   = 8;

   // Register byte offsets
   localparam logic [7:0] A_REQ_W0  = 8'h00;
   localparam logic [7:0] A_REQ_W1  = 8'h04;
   localparam logic [7:0] A_REQ_W2  = 8'h08;
   localparam logic [7:0] A_REQ_PAY = 8'h0C;
   localparam logic [7:0] A_CMD     = 8'h10;
   localparam logic [7:0] A_RSP_W0  = 8'h14;
   localparam logic [7:0] A_RSP_W1  = 8'h18;
   localparam logic [7:0] A_RSP_W2  = 8'h1C;
   localparam logic [7:0] A_RSP_PAY = 8'h20;
   localparam logic [7:0] A_STATUS  = 8'h24;

   // Field positions
   localparam int CMD_GO_BIT   = 0;
   localparam int CMD_MBX_BIT  = 1;
   localparam int CMD_ADDR_LSB = 8;
   localparam int STS_RSP_BIT  = 0;
   localparam int STS_DROP_BIT = 1;
   localparam int STS_NTF_BIT  = 2;
   localparam int STS_POL_LSB  = 8;
   localparam int STS_PEND_LSB = 16;
   localparam int STS_DEST_LSB = 24;

   // Message categories
   localparam logic [3:0] CAT_REQUEST  = 4'h0;
   localparam logic [3:0] CAT_RESPONSE = 4'h1;
   localparam logic [3:0] CAT_NOTIFY   = 4'h2;

   // Opcodes
   localparam logic [15:0] OP_GET_POLICY = 16'h0104;
   localparam logic [15:0] OP_SET_POLICY = 16'h0105;
   localparam logic [15:0] OP_NOTIFY     = 16'h0106;

   // Return codes and lengths
   localparam logic [15:0] RC_SUCCESS     = 16'h0000;
   localparam logic [15:0] RC_INVALID_LEN = 16'h0016;
   localparam logic [20:0] GET_IN_LEN     = 21'h000000;
   localparam logic [20:0] POLICY_LEN     = 21'h000002;
   localparam logic [20:0] NTF_LEN        = 21'h000002;

   // Values after reset
   localparam logic [3:0] POLICY_RST = 4'h0;
endpackage : oen_pkg

// >>> shared/oen_ifs.sv
`timescale 1ns/10ps
// Per-log event tracking signals
interface oen_evt_if;
   import oen_pkg::*;
   logic [NUM_LOGS-1:0] policy;
   logic [NUM_LOGS-1:0] nonempty;
   logic [NUM_LOGS-1:0] clr;
   logic [NUM_LOGS-1:0] pend;
   modport trk (input policy, input nonempty, input clr, output pend);
   modport ctl (output policy, output nonempty, output clr, input pend);
endinterface : oen_evt_if

// Header fields and their packed message words
interface oen_hdr_if;
   logic [3:0]  category;
   logic [7:0]  tag;
   logic [15:0] opcode;
   logic [20:0] plen;
   logic        bg;
   logic [15:0] rc;
   logic [15:0] vs;
   logic [31:0] w0;
   logic [31:0] w1;
   logic [31:0] w2;
   modport pk  (input category, input tag, input opcode, input plen,
                input bg, input rc, input vs,
                output w0, output w1, output w2);
   modport usr (output category, output tag, output opcode, output plen,
                output bg, output rc, output vs,
                input w0, input w1, input w2);
endinterface : oen_hdr_if

// >>> src/oen_hdr_pack.sv
`timescale 1ns/10ps
// Packs header fields into message bytes 0..11, little endian
module oen_hdr_pack (
   // Header fields in, words out
   oen_hdr_if.pk hdr
);
   // Byte 0 category, byte 1 tag, byte 2 reserved, bytes 3-4 opcode
   always_comb begin
      hdr.w0 = {hdr.opcode[7:0], 8'h00, hdr.tag, 4'h0, hdr.category};
      hdr.w1 = {hdr.bg, 2'b00, hdr.plen, hdr.opcode[15:8]};
      hdr.w2 = {hdr.vs, hdr.rc};
   end
endmodule : oen_hdr_pack

// >>> src/oen_log_tracker.sv
`timescale 1ns/10ps
// Catches empty-to-nonempty edges of enabled logs
module oen_log_tracker
   import oen_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Tracking signals
   oen_evt_if.trk    evt
);
   typedef struct packed {
      logic [NUM_LOGS-1:0] prev;
      logic [NUM_LOGS-1:0] pend;
   } oen_trk_s;

   oen_trk_s st_ff;
   oen_trk_s nxt_st;

   // Per-log edge flag; a new edge wins over a clear
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = evt.nonempty;
      for (int i = 0; i < NUM_LOGS; i++) begin
         nxt_st.pend[i] = (evt.nonempty[i] & ~st_ff.prev[i] & evt.policy[i])
            | (st_ff.pend[i] & ~evt.clr[i] & evt.policy[i]);
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign evt.pend = st_ff.pend;
endmodule : oen_log_tracker

// >>> src/oen_event_policy.sv
`timescale 1ns/10ps
// Out-of-band event interrupt policy command handler and notifier
module oen_event_policy
   import oen_pkg::*;
#(
   parameter logic [15:0] RC_INVALID_PARAM  = 16'h0002,
   parameter logic [15:0] RC_UNSUPPORTED    = 16'h0003,
   parameter logic [15:0] RC_INTERNAL_ERROR = 16'h0004,
   parameter logic [15:0] RC_RETRY_REQUIRED = 16'h0005
) (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Device status
   input  wire logic [NUM_LOGS-1:0] log_nonempty,
   input  wire logic                core_fault,
   // Notification message out
   input  wire logic                ntf_ready,
   output logic                     ntf_valid,
   output logic      [31:0]         ntf_w0,
   output logic      [31:0]         ntf_w1,
   output logic      [31:0]         ntf_w2,
   output logic      [31:0]         ntf_pay,
   output logic      [7:0]          ntf_dest
);
   typedef struct packed {
      logic [31:0]         req_w0;
      logic [31:0]         req_w1;
      logic [31:0]         req_w2;
      logic [31:0]         req_pay;
      logic                mbx;
      logic [7:0]          cmd_addr;
      logic [31:0]         rsp_w0;
      logic [31:0]         rsp_w1;
      logic [31:0]         rsp_w2;
      logic [31:0]         rsp_pay;
      logic                rsp_done;
      logic                dropped;
      logic [NUM_LOGS-1:0] policy;
      logic [7:0]          dest;
      logic                ntf_valid;
      logic [1:0]          ntf_log;
      logic [31:0]         ntf_w0;
      logic [31:0]         ntf_w1;
      logic [31:0]         ntf_w2;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } oen_top_s;

   localparam oen_top_s RST_ST = '{policy: POLICY_RST, default: '0};

   // Whole-block state and its next value
   oen_top_s st_ff;
   oen_top_s nxt_st;

   // Carriers to the submodules
   oen_evt_if evt ();
   oen_hdr_if rsp_hdr ();
   oen_hdr_if ntf_hdr ();

   // Request fields as seen in the stored message
   logic [3:0]  req_cat;
   logic [7:0]  req_tag;
   logic [15:0] req_op;
   logic [20:0] req_len;
   logic [15:0] req_pol;

   // Decision results
   logic [15:0] dec_rc;
   logic [20:0] dec_len;
   logic        dec_apply;
   logic        busy_keep;
   logic [3:0]  new_pol;

   // Bus strobes
   logic        wr_en;
   logic        go;

   // Launch selection
   logic [NUM_LOGS-1:0] eff_pol;
   logic [NUM_LOGS-1:0] cand;
   logic [1:0]  sel_log;

   // Read mux
   logic [31:0] rd_data;
   logic        rd_hit;

   // Per-log edge catcher
   oen_log_tracker u_trk (
      .pclk    (pclk),
      .presetn (presetn),
      .evt     (evt.trk)
   );

   // Header packers for the response and the notification
   oen_hdr_pack u_rsp_pack (
      .hdr (rsp_hdr.pk)
   );

   oen_hdr_pack u_ntf_pack (
      .hdr (ntf_hdr.pk)
   );

   // Request header parse; byte 2 and upper nibble of byte 0 ignored
   assign req_cat = st_ff.req_w0[3:0];
   assign req_tag = st_ff.req_w0[15:8];
   assign req_op  = {st_ff.req_w1[7:0], st_ff.req_w0[31:24]};
   assign req_len = st_ff.req_w1[28:8];
   assign req_pol = st_ff.req_pay[15:0];
   assign new_pol = req_pol[3:0];

   // A set keeping the in-flight log enabled gets RC_RETRY_REQUIRED until the hand-off
   assign busy_keep = st_ff.ntf_valid & new_pol[st_ff.ntf_log];

   // Command decode and completion code
   always_comb begin
      dec_rc    = RC_SUCCESS;
      dec_len   = 21'h000000;
      dec_apply = 1'b0;
      if (core_fault) begin
         dec_rc = RC_INTERNAL_ERROR;
      end else if (pwdata[CMD_MBX_BIT] && (req_op == OP_GET_POLICY ||
                   req_op == OP_SET_POLICY || req_op == OP_NOTIFY)) begin
         dec_rc = RC_UNSUPPORTED;
      end else if (req_op == OP_GET_POLICY) begin
         if (req_len != GET_IN_LEN) begin
            dec_rc = RC_INVALID_LEN;
         end else begin
            dec_len = POLICY_LEN;
         end
      end else if (req_op == OP_SET_POLICY) begin
         if (req_len != POLICY_LEN) begin
            dec_rc = RC_INVALID_LEN;
         end else if (busy_keep) begin
            dec_rc = RC_RETRY_REQUIRED;
         end else if (req_pol[15:4] != 12'h000) begin
            dec_rc = RC_INVALID_PARAM;
         end else begin
            dec_len   = POLICY_LEN;
            dec_apply = 1'b1;
         end
      end else begin
         dec_rc = RC_UNSUPPORTED;
      end
   end

   // Response header: echo tag and opcode, clear flag and vendor status
   assign rsp_hdr.category = CAT_RESPONSE;
   assign rsp_hdr.tag      = req_tag;
   assign rsp_hdr.opcode   = req_op;
   assign rsp_hdr.plen     = dec_len;
   assign rsp_hdr.bg       = 1'b0;
   assign rsp_hdr.rc       = dec_rc;
   assign rsp_hdr.vs       = 16'h0000;

   // Notification header is fixed; zero tag, flag, code and status
   assign ntf_hdr.category = CAT_NOTIFY;
   assign ntf_hdr.tag      = 8'h00;
   assign ntf_hdr.opcode   = OP_NOTIFY;
   assign ntf_hdr.plen     = NTF_LEN;
   assign ntf_hdr.bg       = 1'b0;
   assign ntf_hdr.rc       = 16'h0000;
   assign ntf_hdr.vs       = 16'h0000;

   // Tracker sees the stored policy and the raw log levels
   assign evt.policy   = st_ff.policy;
   assign evt.nonempty = log_nonempty;

   // Bus strobes and read mux
   assign wr_en = psel & penable & pwrite & st_ff.pready;
   assign go    = wr_en && (paddr == A_CMD) && pwdata[CMD_GO_BIT];
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h00000000;
      unique case (paddr)
         A_REQ_W0:  rd_data = st_ff.req_w0;
         A_REQ_W1:  rd_data = st_ff.req_w1;
         A_REQ_W2:  rd_data = st_ff.req_w2;
         A_REQ_PAY: rd_data = st_ff.req_pay;
         A_CMD:     rd_data = {16'h0000, st_ff.cmd_addr, 6'h00,
                               st_ff.mbx, 1'b0};
         A_RSP_W0:  rd_data = st_ff.rsp_w0;
         A_RSP_W1:  rd_data = st_ff.rsp_w1;
         A_RSP_W2:  rd_data = st_ff.rsp_w2;
         A_RSP_PAY: rd_data = st_ff.rsp_pay;
         A_STATUS:  rd_data = {st_ff.dest, 4'h0, evt.pend, 4'h0,
                               st_ff.policy, 5'h00, st_ff.ntf_valid,
                               st_ff.dropped, st_ff.rsp_done};
         default:   rd_hit  = 1'b0;
      endcase
   end

   // Launch candidates under the policy in force this cycle
   always_comb begin
      eff_pol = dec_apply && go ? new_pol : st_ff.policy;
      cand    = evt.pend & eff_pol;
      sel_log = 2'd0;
      // Walk down so the lowest pending index wins
      for (int i = NUM_LOGS - 1; i >= 0; i--) begin
         if (cand[i]) begin
            sel_log = 2'(i);
         end
      end
   end

   // Next state of the whole block
   always_comb begin
      nxt_st = st_ff;
      evt.clr = '0;

      // APB: answer in the cycle after setup
      nxt_st.pready = psel & ~penable;
      if (psel && !penable) begin
         nxt_st.prdata  = rd_data;
         nxt_st.pslverr = ~rd_hit;
      end

      // Register writes
      if (wr_en) begin
         unique case (paddr)
            A_REQ_W0:  nxt_st.req_w0  = pwdata;
            A_REQ_W1:  nxt_st.req_w1  = pwdata;
            A_REQ_W2:  nxt_st.req_w2  = pwdata;
            A_REQ_PAY: nxt_st.req_pay = pwdata;
            A_CMD: begin
               nxt_st.mbx      = pwdata[CMD_MBX_BIT];
               nxt_st.cmd_addr = pwdata[CMD_ADDR_LSB +: 8];
            end
            A_STATUS: begin
               nxt_st.rsp_done = st_ff.rsp_done & ~pwdata[STS_RSP_BIT];
               nxt_st.dropped  = st_ff.dropped & ~pwdata[STS_DROP_BIT];
            end
            default: ;
         endcase
      end

      // Command execution; set wins over a same-cycle clear
      if (go) begin
         if (req_cat != CAT_REQUEST) begin
            nxt_st.dropped = 1'b1;
         end else begin
            nxt_st.rsp_w0   = rsp_hdr.w0;
            nxt_st.rsp_w1   = rsp_hdr.w1;
            nxt_st.rsp_w2   = rsp_hdr.w2;
            nxt_st.rsp_pay  = 32'h00000000;
            nxt_st.rsp_done = 1'b1;
            if (dec_len == POLICY_LEN) begin
               nxt_st.rsp_pay = {28'h0000000, eff_pol};
            end
            if (dec_apply) begin
               nxt_st.policy = new_pol;
               nxt_st.dest   = pwdata[CMD_ADDR_LSB +: 8];
            end
         end
      end

      // Notification handshake; accepted one clears its flag
      if (st_ff.ntf_valid && ntf_ready) begin
         nxt_st.ntf_valid = 1'b0;
         evt.clr[st_ff.ntf_log] = 1'b1;
      end else if (st_ff.ntf_valid && !eff_pol[st_ff.ntf_log]) begin
         nxt_st.ntf_valid = 1'b0;
      end else if (!st_ff.ntf_valid && (|cand)) begin
         nxt_st.ntf_valid = 1'b1;
         nxt_st.ntf_log   = sel_log;
         nxt_st.ntf_w0    = ntf_hdr.w0;
         nxt_st.ntf_w1    = ntf_hdr.w1;
         nxt_st.ntf_w2    = ntf_hdr.w2;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= RST_ST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Bus answer straight from state
   assign prdata    = st_ff.prdata;
   assign pready    = st_ff.pready;
   assign pslverr   = st_ff.pslverr;

   // Notification message straight from state
   assign ntf_valid = st_ff.ntf_valid;
   assign ntf_w0    = st_ff.ntf_w0;
   assign ntf_w1    = st_ff.ntf_w1;
   assign ntf_w2    = st_ff.ntf_w2;
   assign ntf_pay   = {30'h00000000, st_ff.ntf_log};
   assign ntf_dest  = st_ff.dest;
endmodule : oen_event_policy

// >>> tb/oen_event_policy_assertions.sv
`timescale 1ns/10ps
// Port checks on the policy handler
module oen_event_policy_chk
   import oen_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Register bus
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   // Notification path
   input wire logic              ntf_ready,
   input wire logic              ntf_valid,
   input wire logic [31:0]       ntf_w0,
   input wire logic [31:0]       ntf_w1,
   input wire logic [31:0]       ntf_w2,
   input wire logic [31:0]       ntf_pay,
   input wire logic [7:0]        ntf_dest
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus phases and the notification hand-off
   sequence setup_s; psel && !penable; endsequence
   sequence accept_s; ntf_valid && ntf_ready; endsequence
   sequence stall_s;
      ntf_valid && !ntf_ready && !(psel && paddr == A_CMD);
   endsequence

   apb_ready_a: assert property (setup_s |=> pready)
      else $error("no answer after setup");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("answer held too long");
   apb_err_a: assert property (psel && !penable && paddr > A_STATUS
      |=> pready && pslverr) else $error("unmapped access not refused");
   map_ok_a: assert property (psel && !penable && paddr <= A_STATUS
      && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped refused");
   ntf_head_a: assert property (ntf_valid |->
      ntf_w0 == {OP_NOTIFY[7:0], 16'h0000, 4'h0, CAT_NOTIFY})
      else $error("notification word 0 wrong");
   ntf_len_a: assert property (ntf_valid |->
      ntf_w1 == {3'b000, NTF_LEN, OP_NOTIFY[15:8]})
      else $error("notification word 1 wrong");
   ntf_zero_a: assert property (ntf_valid |->
      ntf_w2 == 32'h00000000 && ntf_pay[31:2] == 30'h0)
      else $error("notification status or payload wrong");
   ntf_hold_a: assert property (stall_s |=>
      ntf_valid && $stable(ntf_pay) && $stable(ntf_dest))
      else $error("notification changed while waiting");
   ntf_once_a: assert property (accept_s |=> !ntf_valid)
      else $error("notification repeated after accept");
   rst_idle_a: assert property ($rose(presetn) |-> !ntf_valid)
      else $error("notification after reset");
endmodule : oen_event_policy_chk

bind oen_event_policy oen_event_policy_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .ntf_ready(ntf_ready), .ntf_valid(ntf_valid), .ntf_w0(ntf_w0),
   .ntf_w1(ntf_w1), .ntf_w2(ntf_w2), .ntf_pay(ntf_pay),
   .ntf_dest(ntf_dest));

// >>> tb/oen_fm_model.sv
`timescale 1ns/10ps
// Fabric manager end of the notification path
module oen_fm_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Slow answer control
   input  wire logic        stall,
   // Notification in
   input  wire logic        ntf_valid,
   input  wire logic [31:0] ntf_pay,
   input  wire logic [7:0]  ntf_dest,
   output logic             ntf_ready,
   // Seen traffic
   output logic [7:0]       got_cnt,
   output logic [31:0]      got_pay,
   output logic [7:0]       got_dest
);
   // Accept one cycle after a message shows, unless stalled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ntf_ready <= 1'b0;
         got_cnt   <= 8'h00;
         got_pay   <= 32'h00000000;
         got_dest  <= 8'h00;
      end else begin
         ntf_ready <= ntf_valid && !stall && !ntf_ready;
         if (ntf_valid && ntf_ready) begin
            got_cnt  <= got_cnt + 8'h01;
            got_pay  <= ntf_pay;
            got_dest <= ntf_dest;
         end
      end
   end
endmodule : oen_fm_model

// >>> tb/oen_event_policy_tb_top.sv
`timescale 1ns/10ps
// Directed bench for the event policy handler
module oen_event_policy_tb_top;
   import oen_pkg::*;
   localparam logic [15:0] RC_PRM = 16'h0002;
   localparam logic [15:0] RC_UNS = 16'h0003;
   localparam logic [15:0] RC_INT = 16'h0004;
   localparam logic [15:0] RC_RTY = 16'h0005;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        fault, stall, rdy, nv, e;
   logic [7:0]  paddr, tag, dst, cnt, dest, ndst;
   logic [31:0] pwdata, prdata, q, pay, fpay;
   logic [3:0]  lne;
   int          failures, total_checks;

   oen_event_policy #(.RC_INVALID_PARAM(RC_PRM), .RC_UNSUPPORTED(RC_UNS),
      .RC_INTERNAL_ERROR(RC_INT), .RC_RETRY_REQUIRED(RC_RTY)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .log_nonempty(lne),
      .core_fault(fault), .ntf_ready(rdy), .ntf_valid(nv), .ntf_w0(),
      .ntf_w1(), .ntf_w2(), .ntf_pay(pay), .ntf_dest(ndst));
   oen_fm_model fm (.pclk(pclk), .presetn(presetn), .stall(stall),
      .ntf_valid(nv), .ntf_pay(pay), .ntf_dest(ndst), .ntf_ready(rdy),
      .got_cnt(cnt), .got_pay(fpay), .got_dest(dest));

   // Bus clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One bus transfer, held until the answer
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         finish_test();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk($sformatf("register %h", a), exp, q);
   endtask : rd

   // Send one message and compare the response
   task cmd(input logic [3:0] cat, input logic [15:0] op,
            input logic [20:0] len, input logic [31:0] pl, input logic mbx,
            input logic [15:0] rc, input logic [31:0] epay);
      apb(1'b1, A_REQ_W0, {op[7:0], 8'h00, tag, 4'h0, cat});
      apb(1'b1, A_REQ_W1, {3'b000, len, op[15:8]});
      apb(1'b1, A_REQ_W2, 32'h00000000);
      apb(1'b1, A_REQ_PAY, pl);
      apb(1'b1, A_CMD, {16'h0000, dst, 6'h00, mbx, 1'b1});
      if (cat == CAT_REQUEST) begin
         rd(A_RSP_W0, {op[7:0], 8'h00, tag, 4'h0, CAT_RESPONSE});
         rd(A_RSP_W2, {16'h0000, rc});
         rd(A_RSP_W1, {3'b000, (rc == RC_SUCCESS) ? POLICY_LEN : 21'h000000,
                       op[15:8]});
         rd(A_RSP_PAY, epay);
         tag = tag + 8'h01;
      end
   endtask : cmd

   task wait_cnt(input logic [7:0] n);
      int k;
      k = 0;
      while (cnt !== n && k < 30) begin
         @(posedge pclk);
         k++;
      end
      chk("notification count", {24'h0, n}, {24'h0, cnt});
      if (k == 30) finish_test();
   endtask : wait_cnt

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      lne = 4'h8;
      fault = 1'b0;
      stall = 1'b0;
      tag = 8'h00;
      dst = 8'h11;
      failures = 0;
      total_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_STATUS, 32'h00000000);
      rd(8'h40, 32'h00000000);
      chk("unmapped error", 32'h1, {31'h0, e});
      cmd(CAT_REQUEST, OP_GET_POLICY, 0, 0, 0, RC_SUCCESS, 0);
      cmd(CAT_REQUEST, OP_GET_POLICY, 1, 0, 0, RC_INVALID_LEN, 0);
      for (int i = 0; i < 3; i++)
         cmd(CAT_REQUEST, OP_GET_POLICY + i[15:0], 0, 0, 1, RC_UNS, 0);
      cmd(CAT_REQUEST, OP_NOTIFY, 2, 0, 0, RC_UNS, 0);
      cmd(CAT_REQUEST, OP_SET_POLICY, 3, 1, 0, RC_INVALID_LEN, 0);
      fault <= 1'b1;
      cmd(CAT_REQUEST, OP_GET_POLICY, 0, 0, 0, RC_INT, 0);
      cmd(CAT_REQUEST, OP_SET_POLICY, 2, 1, 0, RC_INT, 0);
      fault <= 1'b0;
      $display("test command codes done");
      dst = 8'h5A;
      cmd(CAT_REQUEST, OP_SET_POLICY, 2, 32'hD, 0, RC_SUCCESS, 32'hD);
      dst = 8'h77;
      cmd(CAT_REQUEST, OP_SET_POLICY, 2, 32'h1D, 0, RC_PRM, 0);
      cmd(CAT_REQUEST, OP_GET_POLICY, 0, 0, 0, RC_SUCCESS, 32'hD);
      lne <= 4'hA;
      repeat (8) @(posedge pclk);
      chk("silent count", 32'h0, {24'h0, cnt});
      lne <= 4'hB;
      wait_cnt(8'h01);
      chk("notified log", 32'h0, fpay);
      chk("notified dest", 32'h5A, {24'h0, dest});
      repeat (8) @(posedge pclk);
      chk("repeat count", 32'h1, {24'h0, cnt});
      lne <= 4'hA;
      @(posedge pclk);
      lne <= 4'hB;
      wait_cnt(8'h02);
      $display("test notification done");
      stall <= 1'b1;
      lne <= 4'hF;
      repeat (4) @(posedge pclk);
      chk("held valid", 32'h1, {31'h0, nv});
      cmd(CAT_REQUEST, OP_SET_POLICY, 2, 32'hD, 0, RC_RTY, 0);
      stall <= 1'b0;
      wait_cnt(8'h03);
      chk("stalled log", 32'h2, fpay);
      cmd(CAT_RESPONSE, OP_GET_POLICY, 0, 0, 0, 0, 0);
      rd(A_STATUS, 32'h5A000D03);
      $display("test retry and drop done");
      for (int i = 0; i < 250; i++)
         cmd(CAT_REQUEST, OP_GET_POLICY, 0, 0, 0, RC_SUCCESS, 32'hD);
      $display("test tag wrap done");
      stall <= 1'b1;
      lne <= 4'hB;
      @(posedge pclk);
      lne <= 4'hF;
      repeat (4) @(posedge pclk);
      chk("second held valid", 32'h1, {31'h0, nv});
      dst = 8'h33;
      cmd(CAT_REQUEST, OP_SET_POLICY, 2, 32'h9, 0, RC_SUCCESS, 32'h9);
      chk("dropped valid", 32'h0, {31'h0, nv});
      stall <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("dropped count", 32'h3, {24'h0, cnt});
      rd(A_STATUS, 32'h33000903);
      $display("test disable drop done");
      finish_test();
   end
endmodule : oen_event_policy_tb_top
